// >>> include/baau_pkg.sv
package baau_pkg;

  // opcode bytes
  localparam logic [7:0] OPC_ADD_ADJ = 8'h37;
  localparam logic [7:0] OPC_DIV_ADJ = 8'hD5;
  localparam logic [7:0] OPC_MUL_ADJ = 8'hD4;
  localparam logic [7:0] OPC_BASE_TEN = 8'h0A;

  // execution length in clocks, same on both bus widths
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CYC_ADD_ADJ = 5'h08;
  localparam logic [CNT_W-1:0] CYC_DIV_ADJ = 5'h0F;
  localparam logic [CNT_W-1:0] CYC_MUL_ADJ = 5'h13;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

  // arithmetic constants
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [7:0] ADD_FIX = 8'h06;
  localparam logic [7:0] DEC_TEN = 8'h0A;
  localparam logic [7:0] NIB_MASK = 8'h0F;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RESULT = 8'h0C;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_STATE_LSB = 1;
  localparam int ST_OP_LSB = 4;
  localparam int ST_REJ_BIT = 8;
  localparam int RES_FLAG_LSB = 16;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_ADD = 2'h1,
    OP_DIV = 2'h2,
    OP_MUL = 2'h3
  } baau_op_e;

  // gray along idle -> run -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_DONE = 2'h3
  } baau_state_e;

  typedef struct packed {
    logic ovf;
    logic sgn;
    logic zro;
    logic aux_carry_flag;
    logic par;
    logic carry_flag;
  } baau_flags_s;

  typedef struct packed {
    logic [7:0] opc;
    logic [7:0] base;
  } baau_req_s;

  typedef struct packed {
    logic [15:0] accumulator_word;
    baau_flags_s flags;
    baau_flags_s flag_we;
  } baau_res_s;

endpackage : baau_pkg

// >>> logic/baau_calc.sv
`timescale 1ns/1ps
module baau_calc (
  input baau_pkg::baau_op_e op,
  input wire logic [15:0] accumulator_word,
  input baau_pkg::baau_flags_s flags_in,
  output baau_pkg::baau_res_s res
);
  import baau_pkg::*;

  logic [7:0] acc_low_byte;
  logic [7:0] acc_high_byte;
  logic need_fix;
  logic [7:0] lo_out;

  assign acc_low_byte = accumulator_word[7:0];
  assign acc_high_byte = accumulator_word[15:8];

  // aux carry left by the preceding add is what flags a decimal carry
  assign need_fix = (acc_low_byte[3:0] > BCD_MAX) || flags_in.aux_carry_flag;

  always_comb begin
    lo_out = acc_low_byte;
    res.accumulator_word = accumulator_word;
    res.flags = flags_in;
    res.flag_we = '0;
    case (op)
      OP_ADD: begin
        res.flag_we.carry_flag = 1'b1;
        res.flag_we.aux_carry_flag = 1'b1;
        if (need_fix) begin
          lo_out = (acc_low_byte + ADD_FIX) & NIB_MASK;
          res.accumulator_word = {acc_high_byte + BYTE_ONE, lo_out};
          res.flags.carry_flag = 1'b1;
          res.flags.aux_carry_flag = 1'b1;
        end else begin
          lo_out = acc_low_byte & NIB_MASK;
          res.accumulator_word = {acc_high_byte, lo_out};
          res.flags.carry_flag = 1'b0;
          res.flags.aux_carry_flag = 1'b0;
        end
      end
      OP_DIV: begin
        lo_out = 8'(acc_high_byte * DEC_TEN) + acc_low_byte;
        res.accumulator_word = {BYTE_ZERO, lo_out};
      end
      OP_MUL: begin
        lo_out = acc_low_byte % DEC_TEN;
        res.accumulator_word = {acc_low_byte / DEC_TEN, lo_out};
      end
      default: begin
        lo_out = acc_low_byte;
      end
    endcase
    if (op == OP_DIV || op == OP_MUL) begin
      res.flag_we.sgn = 1'b1;
      res.flag_we.zro = 1'b1;
      res.flag_we.par = 1'b1;
      res.flags.sgn = lo_out[7];
      res.flags.zro = (lo_out == BYTE_ZERO);
      res.flags.par = ~^lo_out;
    end
  end

endmodule : baau_calc

// >>> logic/baau_top.sv
`timescale 1ns/1ps
module baau_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic issue,
  input baau_pkg::baau_req_s req,
  input wire logic [15:0] accumulator_word,
  input baau_pkg::baau_flags_s flags_in,
  output logic busy_ff,
  output logic done_ff,
  output logic reject_ff,
  output baau_pkg::baau_res_s res_ff,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [baau_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff
);
  import baau_pkg::*;

  baau_state_e state_ff;
  baau_state_e nxt_state;
  baau_op_e op_ff;
  baau_op_e dec_op;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] dec_cyc;
  logic [15:0] acc_ff;
  baau_flags_s flags_ff;
  baau_res_s calc_res;
  logic accept;
  logic finish;

  logic en_ff;
  logic clr_cnt;
  logic [15:0] count_ff;
  logic rej_seen_ff;
  logic apb_acc;
  logic apb_hit;
  logic [31:0] rd_mux;
  logic apb_cap;
  logic wr_ctrl;
  logic rd_clr;

  // opcode decode; the base byte must be ten for the two-byte forms
  always_comb begin
    dec_op = OP_NONE;
    dec_cyc = CNT_ZERO;
    case (req.opc)
      OPC_ADD_ADJ: begin
        dec_op = OP_ADD;
        dec_cyc = CYC_ADD_ADJ;
      end
      OPC_DIV_ADJ: begin
        if (req.base == OPC_BASE_TEN) begin
          dec_op = OP_DIV;
          dec_cyc = CYC_DIV_ADJ;
        end
      end
      OPC_MUL_ADJ: begin
        if (req.base == OPC_BASE_TEN) begin
          dec_op = OP_MUL;
          dec_cyc = CYC_MUL_ADJ;
        end
      end
      default: begin
        dec_op = OP_NONE;
      end
    endcase
  end

  // a new request may land in the done cycle so ops run back to back
  assign accept = issue && (state_ff != ST_RUN) && en_ff && (dec_op != OP_NONE);
  assign finish = (state_ff == ST_RUN) && (cnt_ff == CNT_ZERO);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (finish) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (accept) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // cycle counter: loaded with n-1 so the result appears n clocks after issue
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= CNT_ZERO;
    end else if (accept) begin
      cnt_ff <= dec_cyc - CNT_ONE;
    end else if (state_ff == ST_RUN && cnt_ff != CNT_ZERO) begin
      cnt_ff <= cnt_ff - CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy_ff <= 1'b0;
    end else if (accept) begin
      busy_ff <= 1'b1;
    end else if (finish) begin
      busy_ff <= 1'b0;
    end
  end

  // operands are captured at issue; the core may move its buses meanwhile
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      op_ff <= OP_NONE;
    end else if (accept) begin
      op_ff <= dec_op;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc_ff <= 16'h0000;
    end else if (accept) begin
      acc_ff <= accumulator_word;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flags_ff <= '0;
    end else if (accept) begin
      flags_ff <= flags_in;
    end
  end

  baau_calc u_calc (
    .op(op_ff),
    .accumulator_word(acc_ff),
    .flags_in(flags_ff),
    .res(calc_res)
  );

  // result and its write strobe; flags without write enable are left to the core
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= finish;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      res_ff <= '0;
    end else if (finish) begin
      res_ff <= calc_res;
    end
  end

  // refused issue answers with a one-cycle pulse and sets the sticky refusal marker in status
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reject_ff <= 1'b0;
    end else begin
      reject_ff <= issue && !accept;
    end
  end

  // apb: one wait state so that every response comes from a flop
  assign apb_cap = psel && penable && !pready_ff;
  assign apb_acc = psel && penable && pready_ff;
  assign apb_hit = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                   (paddr == REG_COUNT) || (paddr == REG_RESULT);
  assign wr_ctrl = apb_acc && pwrite && (paddr == REG_CTRL) && pstrb[0];
  assign clr_cnt = wr_ctrl && pwdata[CTRL_CLR_BIT];
  // status is captured on the same edge that raises pready; clearing its sticky bit on that
  // same edge keeps a refusal that lands while the access waits
  assign rd_clr = apb_cap && !pwrite && (paddr == REG_STATUS);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= apb_cap;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      en_ff <= CTRL_EN_RST;
    end else if (wr_ctrl) begin
      en_ff <= pwdata[CTRL_EN_BIT];
    end
  end

  // a completion in the clearing cycle is still counted
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_ff <= COUNT_RST;
    end else if (clr_cnt) begin
      count_ff <= finish ? COUNT_ONE : COUNT_RST;
    end else if (finish) begin
      count_ff <= count_ff + COUNT_ONE;
    end
  end

  // sticky refusal marker, cleared by reading status; a new refusal wins
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rej_seen_ff <= 1'b0;
    end else if (issue && !accept) begin
      rej_seen_ff <= 1'b1;
    end else if (rd_clr) begin
      rej_seen_ff <= 1'b0;
    end
  end

  // ctrl holds enable and a write-1 clear of the count; status shows busy,
  // state, last operation and a sticky refusal; count tallies completions
  // and wraps; result mirrors the last answer; other offsets answer with an
  // error and read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      REG_CTRL: begin
        rd_mux[CTRL_EN_BIT] = en_ff;
      end
      REG_STATUS: begin
        rd_mux[ST_BUSY_BIT] = busy_ff;
        rd_mux[ST_STATE_LSB +: 2] = state_ff;
        rd_mux[ST_OP_LSB +: 2] = op_ff;
        rd_mux[ST_REJ_BIT] = rej_seen_ff;
      end
      REG_COUNT: begin
        rd_mux[15:0] = count_ff;
      end
      REG_RESULT: begin
        rd_mux[15:0] = res_ff.accumulator_word;
        rd_mux[RES_FLAG_LSB +: 6] = res_ff.flags;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= 32'h00000000;
    end else if (apb_cap && !pwrite) begin
      prdata_ff <= rd_mux;
    end else begin
      prdata_ff <= 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pslverr_ff <= 1'b0;
    end else if (apb_cap) begin
      pslverr_ff <= !apb_hit;
    end else begin
      pslverr_ff <= 1'b0;
    end
  end

endmodule : baau_top

// >>> test/baau_chk.sv
`timescale 1ns/1ps
module baau_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic issue,
  input baau_pkg::baau_req_s req,
  input wire logic [15:0] accumulator_word,
  input baau_pkg::baau_flags_s flags_in,
  input wire logic busy_ff,
  input wire logic done_ff,
  input wire logic reject_ff,
  input baau_pkg::baau_res_s res_ff,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready_ff
);
  import baau_pkg::*;
  logic [15:0] a_ff;
  logic [7:0] o_ff;
  logic af_ff;
  wire logic [15:0] m = res_ff.accumulator_word;
  wire logic fix_w = (a_ff[3:0] > BCD_MAX) || af_ff;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // refused idle requests also land here, but no done can follow them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      a_ff <= 16'h0000;
      o_ff <= 8'h00;
      af_ff <= 1'b0;
    end else if (issue && !busy_ff) begin
      a_ff <= accumulator_word;
      o_ff <= req.opc;
      af_ff <= flags_in.aux_carry_flag;
    end
  end
  lat_add_a: assert property ($rose(busy_ff) && o_ff == OPC_ADD_ADJ |-> busy_ff[*8] ##1
    (done_ff && !busy_ff)) else $error("add adjust latency wrong");
  lat_div_a: assert property ($rose(busy_ff) && o_ff == OPC_DIV_ADJ |-> ##15
    (done_ff && !busy_ff)) else $error("divide adjust latency wrong");
  lat_mul_a: assert property ($rose(busy_ff) && o_ff == OPC_MUL_ADJ |-> ##19
    (done_ff && !busy_ff)) else $error("multiply adjust latency wrong");
  add_fix_a: assert property (done_ff && o_ff == OPC_ADD_ADJ && fix_w
    |-> m == {a_ff[15:8] + BYTE_ONE, (a_ff[7:0] + ADD_FIX) & NIB_MASK}
    && res_ff.flags.carry_flag && res_ff.flags.aux_carry_flag) else $error("add fix wrong");
  add_keep_a: assert property (done_ff && o_ff == OPC_ADD_ADJ && !fix_w
    |-> m == {a_ff[15:8], a_ff[7:0] & NIB_MASK}
    && !res_ff.flags.carry_flag && !res_ff.flags.aux_carry_flag) else $error("add keep wrong");
  div_val_a: assert property (done_ff && o_ff == OPC_DIV_ADJ
    |-> m == {BYTE_ZERO, a_ff[15:8] * DEC_TEN + a_ff[7:0]}) else $error("divide value wrong");
  mul_val_a: assert property (done_ff && o_ff == OPC_MUL_ADJ
    |-> m == {a_ff[7:0] / DEC_TEN, a_ff[7:0] % DEC_TEN}) else $error("multiply value wrong");
  szp_set_a: assert property (done_ff && (o_ff == OPC_DIV_ADJ || o_ff == OPC_MUL_ADJ)
    |-> res_ff.flags.sgn == m[7] && res_ff.flags.zro == (m[7:0] == BYTE_ZERO)
    && res_ff.flags.par == ~^m[7:0] && res_ff.flag_we.sgn && res_ff.flag_we.zro
    && res_ff.flag_we.par) else $error("sign zero parity wrong");
  busy_rej_a: assert property (issue && busy_ff |=> reject_ff) else $error("busy issue kept");
  apb_wait_a: assert property (psel && $rose(penable) |-> !pready_ff ##1 pready_ff)
    else $error("apb wait state wrong");
  cover property (done_ff && o_ff == OPC_ADD_ADJ);
  cover property (done_ff && o_ff == OPC_DIV_ADJ);
  cover property (done_ff && o_ff == OPC_MUL_ADJ);
endmodule : baau_chk

bind baau_top baau_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .issue(issue), .req(req),
  .accumulator_word(accumulator_word), .flags_in(flags_in), .busy_ff(busy_ff),
  .done_ff(done_ff), .reject_ff(reject_ff), .res_ff(res_ff), .psel(psel),
  .penable(penable), .pready_ff(pready_ff));

// >>> test/baau_core_mdl.sv
`timescale 1ns/1ps
module baau_core_mdl (
  input wire logic ref_clk,
  input wire logic busy_ff,
  input wire logic done_ff,
  input wire logic reject_ff,
  output logic issue,
  output baau_pkg::baau_req_s req,
  output logic [15:0] accumulator_word,
  output baau_pkg::baau_flags_s flags_in
);
  import baau_pkg::*;
  initial begin
    issue = 1'b0;
    req = 16'h0000;
    accumulator_word = 16'h0000;
    flags_in = 6'h00;
  end
  // operands are inverted once released, so a late sample cannot pass by luck
  task automatic op(input logic [7:0] o, input logic [7:0] b, input logic [15:0] a,
    input logic [5:0] f, input int n, output logic dn, output logic rj, output int cyc);
    dn = 1'b0;
    rj = 1'b0;
    @(posedge ref_clk);
    issue <= 1'b1;
    req <= {o, b};
    accumulator_word <= a;
    flags_in <= f;
    repeat (n) @(posedge ref_clk);
    issue <= 1'b0;
    req <= ~{o, b};
    accumulator_word <= ~a;
    flags_in <= ~f;
    cyc = n - 1;
    while (!dn && !(rj && busy_ff !== 1'b1) && cyc < 40) begin
      @(negedge ref_clk);
      if (done_ff === 1'b1)
        dn = 1'b1;
      else
        cyc++;
      if (reject_ff === 1'b1)
        rj = 1'b1;
    end
  endtask : op
endmodule : baau_core_mdl

// >>> test/bcd_ascii_adjust_unit_tb.sv
`timescale 1ns/1ps
module bcd_ascii_adjust_unit_tb;
  import baau_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  wire logic issue, busy_ff, done_ff, reject_ff, pready_ff, pslverr_ff;
  baau_req_s req;
  baau_flags_s flags_in;
  logic [15:0] accumulator_word;
  baau_res_s res_ff;
  logic [31:0] prdata_ff, q;
  logic e, dn, rj;
  int err_total = 0, samples_checked = 0, cyc;
  always #12.5 ref_clk = ~ref_clk;
  baau_top dut (.ref_clk(ref_clk), .nrst(nrst), .issue(issue), .req(req),
    .accumulator_word(accumulator_word), .flags_in(flags_in), .busy_ff(busy_ff),
    .done_ff(done_ff), .reject_ff(reject_ff), .res_ff(res_ff), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff));
  baau_core_mdl core (.ref_clk(ref_clk), .busy_ff(busy_ff), .done_ff(done_ff),
    .reject_ff(reject_ff), .issue(issue), .req(req), .accumulator_word(accumulator_word),
    .flags_in(flags_in));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready_ff !== 1'b1 && k < 20);
    q = prdata_ff;
    e = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready_ff !== 1'b1) begin
      err_total++;
      $display("Error at %0t pready %h expected %h", $time, pready_ff, 1'b1);
      wrap_up();
    end
  endtask : apb
  task automatic drive(input logic [7:0] o, input logic [7:0] b, input logic [15:0] a,
    input logic [5:0] f, input int n);
    core.op(o, b, a, f, n, dn, rj, cyc);
    if (cyc >= 40) begin
      err_total++;
      $display("Error at %0t wait ran out, cycles %h expected below %h", $time, cyc, 40);
      wrap_up();
    end
  endtask : drive
  // flags outside the mask are left undefined by the operation, so only masked bits are judged
  task automatic run(input logic [7:0] o, input logic [15:0] a, input logic [5:0] f,
    input int ecyc, input logic [15:0] eacc, input logic [5:0] m, input logic [5:0] ef);
    drive(o, OPC_BASE_TEN, a, f, 1);
    chk({dn, rj}, 2'b10);
    chk(cyc, ecyc);
    chk(res_ff.accumulator_word, eacc);
    chk({res_ff.flag_we & m, res_ff.flags & m}, {m, ef});
  endtask : run
  task automatic t_add();
    run(OPC_ADD_ADJ, 16'h000C, 6'h00, 8, 16'h0102, 6'h05, 6'h05);
    run(OPC_ADD_ADJ, 16'h0005, 6'h04, 8, 16'h010B, 6'h05, 6'h05);
    run(OPC_ADD_ADJ, 16'h0305, 6'h00, 8, 16'h0305, 6'h05, 6'h00);
    run(OPC_ADD_ADJ, 16'h0239, 6'h01, 8, 16'h0209, 6'h05, 6'h00);
    $display("t_add finished");
  endtask : t_add
  task automatic t_div();
    run(OPC_DIV_ADJ, 16'h0409, 6'h3F, 15, 16'h0031, 6'h1A, 6'h00);
    run(OPC_DIV_ADJ, 16'h0909, 6'h00, 15, 16'h0063, 6'h1A, 6'h02);
    $display("t_div finished");
  endtask : t_div
  task automatic t_mul();
    run(OPC_MUL_ADJ, 16'h002A, 6'h3F, 19, 16'h0402, 6'h1A, 6'h00);
    run(OPC_MUL_ADJ, 16'h0044, 6'h00, 19, 16'h0608, 6'h1A, 6'h00);
    run(OPC_MUL_ADJ, 16'h5500, 6'h00, 19, 16'h0000, 6'h1A, 6'h0A);
    $display("t_mul finished");
  endtask : t_mul
  task automatic t_refuse();
    drive(OPC_ADD_ADJ, 8'h00, 16'h000C, 6'h00, 2);
    chk({dn, rj, cyc[7:0]}, {2'b11, 8'h08});
    drive(8'h3F, 8'h00, 16'h0001, 6'h00, 1);
    chk({dn, rj}, 2'b01);
    drive(OPC_DIV_ADJ, 8'h0B, 16'h0101, 6'h00, 1);
    chk({dn, rj}, 2'b01);
    drive(OPC_MUL_ADJ, 8'h0B, 16'h0011, 6'h00, 1);
    chk({dn, rj}, 2'b01);
    $display("t_refuse finished");
  endtask : t_refuse
  task automatic t_regs();
    apb(1'b0, REG_CTRL, 32'h00000000);
    chk(q[1:0], 2'h1);
    apb(1'b0, REG_STATUS, 32'h00000000);
    chk(q[8:0], 9'h110);
    apb(1'b0, REG_STATUS, 32'h00000000);
    chk(q[8], 1'b0);
    apb(1'b0, REG_COUNT, 32'h00000000);
    chk(q, 32'h0000000A);
    apb(1'b0, REG_RESULT, 32'h00000000);
    chk(q[15:0], 16'h0102);
    apb(1'b0, 8'h10, 32'h00000000);
    chk({e, q[30:0]}, 32'h80000000);
    apb(1'b1, REG_CTRL, 32'h00000000);
    drive(OPC_ADD_ADJ, 8'h00, 16'h0003, 6'h00, 1);
    chk({dn, rj}, 2'b01);
    apb(1'b1, REG_CTRL, 32'h00000003);
    apb(1'b0, REG_COUNT, 32'h00000000);
    chk(q, 32'h00000000);
    $display("t_regs finished");
  endtask : t_regs
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    t_add();
    t_div();
    t_mul();
    t_refuse();
    t_regs();
    wrap_up();
  end
endmodule : bcd_ascii_adjust_unit_tb
